// File: inc/thcm_pkg.sv
// constants, field layouts and state types of the two-hand control monitor
`default_nettype none
package thcm_pkg;
    // clock and timing figures, counter width and sizes
    localparam int CLK_KHZ   = 50000;
    localparam int SIMUL_MS  = 500;
    localparam int ALL_MS    = 15000;
    localparam int SWITCH_MS = 50;
    localparam int BLINK_MS  = 250;
    localparam int SIMUL_CYC  = SIMUL_MS * CLK_KHZ;
    localparam int ALL_CYC    = ALL_MS * CLK_KHZ;
    localparam int SWITCH_CYC = SWITCH_MS * CLK_KHZ;
    localparam int BLINK_CYC  = BLINK_MS * CLK_KHZ;
    localparam int CNT_W      = 30;
    localparam int NPAIR      = 4;
    localparam int NBTN       = 8;
    localparam int NIN        = 20;
    // register byte offsets
    localparam logic [3:0] ADR_CTRL     = 4'h0;
    localparam logic [3:0] ADR_STATUS   = 4'h4;
    localparam logic [3:0] ADR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADR_IRQ_MASK = 4'hc;
    // control fields
    localparam int CTRL_COMBINED = 0;
    localparam int CTRL_PAIRS_LO = 1;
    localparam int CTRL_CHANGE   = 3;
    localparam int CTRL_FEEDBACK = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // interrupt status bits and failure codes
    localparam int IRQ_ON     = 0;
    localparam int IRQ_OFF    = 1;
    localparam int IRQ_SWITCH = 2;
    localparam int IRQ_ESTOP  = 3;
    localparam logic [3:0] FAULT_SWITCHOVER = 4'h7;
    localparam logic [3:0] FAULT_NONE       = 4'h0;

    typedef enum logic [2:0] {
        ST_RELEASE,
        ST_START,
        ST_ARMED,
        ST_ACTIVE,
        ST_FAULT
    } thcm_state_type;

    // pin group, filtered as one vector
    typedef struct packed {
        logic             ack;
        logic             feedback;
        logic [1:0]       estop;
        logic [NBTN-1:0]  nc;
        logic [NBTN-1:0]  no;
    } thcm_pins_type;
endpackage
`default_nettype wire

// File: rtl/thcm_top.sv
// two-hand control monitor with e-stop loop, wishbone registers and interrupt
//
// The register addresses and register access over Wishbone were left to the implementer.
`default_nettype none
module thcm_top
    import thcm_pkg::*;
#(
    parameter logic [CNT_W-1:0] SIMUL_CNT  = CNT_W'(SIMUL_CYC),
    parameter logic [CNT_W-1:0] ALL_CNT    = CNT_W'(ALL_CYC),
    parameter logic [CNT_W-1:0] SWITCH_CNT = CNT_W'(SWITCH_CYC),
    parameter logic [CNT_W-1:0] BLINK_CNT  = CNT_W'(BLINK_CYC)
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic [NBTN-1:0] btn_no_i,
    input  wire logic [NBTN-1:0] btn_nc_i,
    input  wire logic [1:0]      estop_loop_i,
    input  wire logic            contactor_feedback_input_i,
    input  wire logic            acknowledge_button_input_i,
    output logic                 safety_relay_a_o,
    output logic                 safety_relay_b_o,
    output logic                 indicator_status_o,
    output logic                 indicator_start_o,
    output logic      [3:0]      failure_code_o,
    output logic                 irq_o
);
    typedef struct packed {
        thcm_pins_type                s1;
        thcm_pins_type                s2;
        thcm_pins_type                s3;
        thcm_pins_type                filt;
        logic                         ack_prev;
        logic                         estop_prev;
        thcm_state_type               st;
        logic [NPAIR-1:0][CNT_W-1:0]  pair_cnt;
        logic [NPAIR-1:0]             pair_run;
        logic [NPAIR-1:0]             pair_ok;
        logic [CNT_W-1:0]             all_cnt;
        logic                         all_run;
        logic [CNT_W-1:0]             sw_cnt;
        logic [CNT_W-1:0]             blink_cnt;
        logic                         blink;
        logic                         ack_stuck;
        logic                         fb_fault;
        logic                         relay;
        logic                         ind_status;
        logic                         ind_start;
        logic [3:0]                   fault_code;
        logic [4:0]                   ctrl;
        logic [3:0]                   irq_stat;
        logic [3:0]                   irq_mask;
        logic                         irq;
        logic                         wb_ack;
        logic [31:0]                  wb_dat;
        logic [2:0]                   warm;
    } thcm_regs_type;

    thcm_regs_type   r;
    thcm_regs_type   next_r;
    thcm_pins_type   pins;
    logic            combined;
    logic [1:0]      npairs_m1;
    logic            change_mode;
    logic [NBTN-1:0] btn_en;
    logic [NBTN-1:0] pressed;
    logic [NBTN-1:0] released;
    logic [NBTN-1:0] transit;
    logic [NPAIR-1:0] pair_en;
    logic [NPAIR-1:0] pair_both;
    logic [NPAIR-1:0] pair_any;
    logic            all_released;
    logic            any_press;
    logic            estop_ok;
    logic            fb_ok;
    logic            ack_rise;
    logic            sw_fault;
    logic            fail;
    logic            flash_cond;
    logic [3:0]      events;
    logic [3:0]      w1c;
    logic            bus_wr;
    localparam logic [2:0] WARM_DONE = 3'h4; // filter output holds real pin levels from here

    assign pins = '{ack: acknowledge_button_input_i, feedback: contactor_feedback_input_i,
                    estop: estop_loop_i, nc: btn_nc_i, no: btn_no_i};

    // the whole block: filters, sequence, indicators and register slave
    always_comb begin
        next_r = r;
        // three-stage filter, value taken once stages two and three agree
        next_r.s1 = pins;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.filt = (r.s2 ~^ r.s3) & r.s3 | (r.s2 ^ r.s3) & r.filt;

        combined    = r.ctrl[CTRL_COMBINED];
        change_mode = r.ctrl[CTRL_CHANGE];
        // combined mode never watches more than two pairs
        npairs_m1 = r.ctrl[CTRL_PAIRS_LO +: 2];
        if (combined && npairs_m1 > 2'h1) begin
            npairs_m1 = 2'h1;
        end
        for (int p = 0; p < NPAIR; p++) begin
            pair_en[p]        = (2'(p) <= npairs_m1);
            btn_en[2*p]       = pair_en[p];
            btn_en[2*p+1]     = pair_en[p];
        end
        // changeover buttons: no and nc agreeing is a transit position
        for (int b = 0; b < NBTN; b++) begin
            pressed[b]  = change_mode ? (r.filt.no[b] && !r.filt.nc[b]) : r.filt.no[b];
            released[b] = change_mode ? (!r.filt.no[b] && r.filt.nc[b]) : !r.filt.no[b];
            transit[b]  = change_mode && btn_en[b] && (r.filt.no[b] == r.filt.nc[b]);
        end
        for (int p = 0; p < NPAIR; p++) begin
            pair_both[p] = pressed[2*p] && pressed[2*p+1];
            pair_any[p]  = !(released[2*p] && released[2*p+1]);
        end
        all_released = &(released | ~btn_en);
        any_press    = |(pair_any & pair_en);
        estop_ok     = &r.filt.estop;
        fb_ok        = !r.ctrl[CTRL_FEEDBACK] || r.filt.feedback;
        ack_rise     = r.filt.ack && !r.ack_prev;
        next_r.ack_prev   = r.filt.ack;
        next_r.estop_prev = estop_ok;
        // after reset the filter reads zero, which would look like released buttons
        next_r.warm = (r.warm == WARM_DONE) ? r.warm : r.warm + 3'h1;
        bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && r.wb_ack;

        // transfer timer runs while any watched button is between contacts
        sw_fault = 1'b0;
        if (|transit) begin
            next_r.sw_cnt = r.sw_cnt + CNT_W'(1);
            sw_fault = (r.sw_cnt + CNT_W'(1) >= SWITCH_CNT);
        end else begin
            next_r.sw_cnt = '0;
        end

        // indicator flash base
        if (r.blink_cnt >= BLINK_CNT - CNT_W'(1)) begin
            next_r.blink_cnt = '0;
            next_r.blink     = !r.blink;
        end else begin
            next_r.blink_cnt = r.blink_cnt + CNT_W'(1);
        end

        fail = 1'b0;
        case (r.st)
            ST_RELEASE: begin
                next_r.pair_ok  = '0;
                next_r.pair_run = '0;
                next_r.all_run  = 1'b0;
                next_r.fb_fault = 1'b0;
                next_r.all_cnt  = '0;
                next_r.pair_cnt = '0;
                // every configured pair must first be seen at rest, through a settled filter
                if (r.warm == WARM_DONE && all_released && (!combined || estop_ok)) begin
                    next_r.st = combined ? ST_START : ST_ARMED;
                    next_r.ack_stuck = combined && r.filt.ack;
                end
            end
            ST_START: begin
                // a held acknowledge button never counts as a start
                if (!r.filt.ack) begin
                    next_r.ack_stuck = 1'b0;
                end
                if (!estop_ok || !all_released) begin
                    next_r.st = ST_RELEASE;
                end else if (ack_rise) begin
                    next_r.st = ST_ARMED;
                end
            end
            ST_ARMED: begin
                for (int p = 0; p < NPAIR; p++) begin
                    if (pair_en[p]) begin
                        if (r.pair_ok[p]) begin
                            // let go before activation spoils the attempt
                            if (!pair_both[p]) begin
                                fail = 1'b1;
                            end
                        end else if (pair_any[p]) begin
                            next_r.pair_run[p] = 1'b1;
                            next_r.pair_cnt[p] = r.pair_run[p] ? r.pair_cnt[p] + CNT_W'(1) : '0;
                            if (pair_both[p]) begin
                                next_r.pair_ok[p] = 1'b1;
                            end else if (r.pair_run[p] && r.pair_cnt[p] + CNT_W'(1) >= SIMUL_CNT) begin
                                fail = 1'b1;
                            end
                        end else begin
                            next_r.pair_run[p] = 1'b0;
                            next_r.pair_cnt[p] = '0;
                        end
                    end
                end
                // window for all pairs opens at the first press of any
                if (any_press) begin
                    next_r.all_run = 1'b1;
                    next_r.all_cnt = r.all_run ? r.all_cnt + CNT_W'(1) : '0;
                    if (r.all_run && r.all_cnt + CNT_W'(1) >= ALL_CNT) begin
                        fail = 1'b1;
                    end
                end
                if (combined && !estop_ok) begin
                    fail = 1'b1;
                end
                next_r.fb_fault = ((next_r.pair_ok & pair_en) == pair_en) && !fb_ok;
                if (fail) begin
                    next_r.st = ST_RELEASE;
                end else if ((next_r.pair_ok & pair_en) == pair_en && fb_ok) begin
                    next_r.st = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                // any release, or an open loop in combined mode, drops out and demands a new start
                if ((pair_both & pair_en) != pair_en || (combined && !estop_ok)) begin
                    next_r.st = ST_RELEASE;
                end
            end
            ST_FAULT: begin
                next_r.st = ST_FAULT;
            end
            default: begin
                next_r.st = ST_RELEASE;
            end
        endcase
        // a new setting restarts the sequence, so combined mode always waits for a start
        if (bus_wr && wb_adr_i == ADR_CTRL && r.st != ST_FAULT) begin
            next_r.st = ST_RELEASE;
        end
        // switchover failure overrides everything and stays until reset
        if (sw_fault) begin
            next_r.st = ST_FAULT;
        end
        next_r.relay      = (next_r.st == ST_ACTIVE);
        next_r.fault_code = (next_r.st == ST_FAULT) ? FAULT_SWITCHOVER : FAULT_NONE;

        // indicators
        flash_cond = (combined && !estop_ok) || r.fb_fault || r.ack_stuck || r.st == ST_FAULT;
        next_r.ind_status = flash_cond ? r.blink : all_released;
        case (next_r.st)
            ST_ACTIVE: next_r.ind_start = 1'b1;
            ST_START:  next_r.ind_start = r.blink;
            default:   next_r.ind_start = 1'b0;
        endcase

        // interrupt sources
        events[IRQ_ON]     = next_r.relay && !r.relay;
        events[IRQ_OFF]    = !next_r.relay && r.relay;
        events[IRQ_SWITCH] = sw_fault && r.st != ST_FAULT;
        events[IRQ_ESTOP]  = combined && r.estop_prev && !estop_ok;

        // wishbone classic slave, one wait state, ack for one cycle; writes land at the ack edge
        w1c = (bus_wr && wb_adr_i == ADR_IRQ_STAT) ? wb_dat_i[3:0] : 4'h0;
        next_r.wb_ack = wb_cyc_i && wb_stb_i && !r.wb_ack;
        next_r.wb_dat = 32'h0000_0000;
        if (bus_wr) begin
            case (wb_adr_i)
                ADR_CTRL:     next_r.ctrl = wb_dat_i[4:0];
                ADR_IRQ_MASK: next_r.irq_mask = wb_dat_i[3:0];
                default:      ;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && !r.wb_ack) begin
            case (wb_adr_i)
                ADR_CTRL:     next_r.wb_dat = {27'h0, r.ctrl};
                ADR_STATUS:   next_r.wb_dat = {16'h0, r.ind_start, r.ind_status, r.fb_fault,
                                               r.ack_stuck, r.pair_ok, r.fault_code, r.relay, r.st};
                ADR_IRQ_STAT: next_r.wb_dat = {28'h0, r.irq_stat};
                ADR_IRQ_MASK: next_r.wb_dat = {28'h0, r.irq_mask};
                default:      next_r.wb_dat = 32'h0000_0000;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_r.irq_stat = (r.irq_stat & ~w1c) | events;
        next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
    end

    // single state register; reset also stands for loss of supply
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign wb_dat_o           = r.wb_dat;
    assign wb_ack_o           = r.wb_ack;
    assign safety_relay_a_o   = r.relay;
    assign safety_relay_b_o   = r.relay;
    assign indicator_status_o = r.ind_status;
    assign indicator_start_o  = r.ind_start;
    assign failure_code_o     = r.fault_code;
    assign irq_o              = r.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_relay_from_armed: assert property ($rose(r.relay) |-> $past(r.st) == ST_ARMED)
        else $error("relays energized without passing the armed state");
    a_armed_after_start: assert property (
        (r.st == ST_ARMED && $past(r.st) != ST_ARMED && $past(combined)) |-> $past(r.st) == ST_START)
        else $error("combined mode armed without a start");
    a_start_needs_loop: assert property ((r.st == ST_START && !estop_ok && !sw_fault) |=> r.st == ST_RELEASE)
        else $error("open loop did not cancel the start wait");
    a_pair_window: assert property (
        (r.st == ST_ARMED && pair_en[0] && r.pair_run[0] && pair_any[0] && !pair_both[0] && !r.pair_ok[0]
         && r.pair_cnt[0] == SIMUL_CNT - CNT_W'(1)) |=> (r.st == ST_RELEASE || r.st == ST_FAULT))
        else $error("pair accepted after the simultaneity window");
    a_all_window: assert property (r.st == ST_ARMED |-> r.all_cnt < ALL_CNT)
        else $error("all-pairs window overran");
    a_switch_fault: assert property ((|transit && r.sw_cnt == SWITCH_CNT - CNT_W'(1))
        |=> r.st == ST_FAULT ##1 (failure_code_o == 4'h7 && !safety_relay_a_o))
        else $error("long transfer did not raise failure code 7");
    a_fault_latched: assert property (r.st == ST_FAULT |=> r.st == ST_FAULT && !r.relay)
        else $error("switchover failure left its latch");
    a_estop_flash: assert property ((combined && !estop_ok && r.st != ST_FAULT)
        |=> indicator_status_o == $past(r.blink))
        else $error("status indicator not flashing on open loop");
    a_start_steady: assert property (r.st == ST_ACTIVE |-> indicator_start_o && safety_relay_b_o)
        else $error("start indicator not steady while energized");
    a_pair_limit: assert property (combined |-> !pair_en[2] && !pair_en[3])
        else $error("combined mode watching more than two pairs");

    c_activation:  cover property (r.st == ST_ARMED ##1 r.st == ST_ACTIVE);
    c_combined_on: cover property (combined && r.st == ST_START ##[1:20] r.st == ST_ARMED);
    c_switch_flt:  cover property ($rose(r.st == ST_FAULT));
    c_irq:         cover property ($rose(irq_o));
endmodule
`default_nettype wire

// File: verification/thcm_operator_model.sv
// operator side model: buttons with changeover transit, e-stop loop, start button, contactors
`default_nettype none
module thcm_operator_model
    import thcm_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic [NBTN-1:0] press_i,
    input  wire logic [7:0]      transit_i,
    input  wire logic            loop_closed_i,
    input  wire logic            ack_press_i,
    input  wire logic            fb_break_i,
    input  wire logic            relay_i,
    output logic      [NBTN-1:0] btn_no_o,
    output logic      [NBTN-1:0] btn_nc_o,
    output logic      [1:0]      estop_loop_o,
    output logic                 feedback_o,
    output logic                 ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NBTN-1:0] cur  = '0;
    logic [NBTN-1:0] tgt  = '0;
    logic [7:0]      cnt  = 8'h00;
    logic            fb_q = 1'b1;
    // a moving contact leaves both sides open for transit_i cycles, as a slow operator would
    always @(posedge clk_i) begin
        fb_q <= ~relay_i;
        if (cnt != 8'h00) begin
            cnt <= (cnt >= transit_i) ? 8'h00 : cnt + 8'h01;
            if (cnt >= transit_i) cur <= tgt;
        end else if (press_i != cur) begin
            tgt <= press_i;
            if (transit_i == 8'h00) cur <= press_i;
            else cnt <= 8'h01;
        end
    end
    // contactors drop with the relay, feedback closes one cycle later unless broken on purpose
    assign btn_no_o     = (cnt != 8'h00) ? (cur & tgt) : cur;
    assign btn_nc_o     = (cnt != 8'h00) ? ~(cur | tgt) : ~cur;
    assign estop_loop_o = {2{loop_closed_i}};
    assign feedback_o   = fb_q & ~fb_break_i;
    assign ack_o        = ack_press_i;
endmodule
`default_nettype wire

// File: verification/tb_two_hand_control_monitor.sv
// self-checking bench of the two-hand control monitor with its operator model
`default_nettype none
module tb_two_hand_control_monitor
    import thcm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic            loop_c = 1'b1, ack_p = 1'b0, fb_brk = 1'b0;
    logic [3:0]      adr = 4'h0, fcode;
    logic [31:0]     wdat = 32'h0, rdo;
    logic [NBTN-1:0] press = '0, no, nc;
    logic [7:0]      transit = 8'h00;
    logic [1:0]      estop;
    logic            fb, ack_b, ra, rb, lamp_s, lamp_g, irq, wack;
    int              n_fail = 0, cmp_count = 0;

    // short windows keep the run brief: 40, 200, 10 and 4 cycles
    thcm_top #(.SIMUL_CNT(30'h28), .ALL_CNT(30'hc8), .SWITCH_CNT(30'ha), .BLINK_CNT(30'h4)) thcm_top_inst (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(wack), .btn_no_i(no), .btn_nc_i(nc),
        .estop_loop_i(estop), .contactor_feedback_input_i(fb), .acknowledge_button_input_i(ack_b),
        .safety_relay_a_o(ra), .safety_relay_b_o(rb), .indicator_status_o(lamp_s),
        .indicator_start_o(lamp_g), .failure_code_o(fcode), .irq_o(irq));
    thcm_operator_model thcm_operator_model_inst (
        .clk_i(clk), .press_i(press), .transit_i(transit), .loop_closed_i(loop_c), .ack_press_i(ack_p),
        .fb_break_i(fb_brk), .relay_i(ra), .btn_no_o(no), .btn_nc_o(nc), .estop_loop_o(estop),
        .feedback_o(fb), .ack_o(ack_b));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle: request held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no local limit: only the watchdog may end a hung wait
        do begin
            @(posedge clk);
        end while (wack !== 1'b1);
        q = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic set_btn(input logic [NBTN-1:0] v, input int n);
        @(posedge clk);
        press <= v;
        cycles(n);
    endtask

    // bounded wait for the relays, then both must show the same level
    task automatic relay(input logic e);
        int n;
        n = 0;
        while (ra !== e && n < 16) begin
            @(posedge clk);
            n++;
        end
        chk({30'h0, ra, rb}, {30'h0, e, e});
    endtask

    // lamp pattern over 24 cycles: 0 off, 1 steady, 2 flashing
    task automatic lamp(input logic which, input logic [1:0] mode);
        int   tg;
        logic p;
        logic v;
        tg = 0;
        p = which ? lamp_g : lamp_s;
        v = p;
        repeat (24) begin
            @(posedge clk);
            v = which ? lamp_g : lamp_s;
            if (v !== p) tg++;
            p = v;
        end
        chk({30'h0, (tg > 2) ? 2'h2 : {1'b0, v}}, {30'h0, mode});
    endtask

    task automatic t_regs;
        logic [31:0] q;
        wb(1'b0, ADR_CTRL, 32'h0, q);
        chk(q, 32'h0);
        wr(4'h2, 32'h1f);
        wb(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, ADR_CTRL, 32'h0, q);
        chk(q, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_pair;
        @(posedge clk);
        press <= 8'h03;
        rst <= 1'b1;
        cycles(2);
        rst <= 1'b0;
        cycles(16);
        relay(1'b0);
        set_btn(8'h00, 12);
        lamp(1'b0, 2'h1);
        wr(ADR_IRQ_MASK, 32'h1);
        set_btn(8'h03, 0);
        relay(1'b1);
        lamp(1'b1, 2'h1);
        chk({31'h0, irq}, 32'h1);
        wr(ADR_IRQ_STAT, 32'h1);
        cycles(2);
        chk({31'h0, irq}, 32'h0);
        set_btn(8'h01, 0);
        relay(1'b0);
        set_btn(8'h00, 12);
        $display("test pair done");
    endtask

    // second button too late must not count; just inside the window it must
    task automatic t_simul;
        set_btn(8'h01, 50);
        set_btn(8'h03, 16);
        relay(1'b0);
        set_btn(8'h00, 12);
        set_btn(8'h01, 30);
        set_btn(8'h03, 0);
        relay(1'b1);
        set_btn(8'h00, 16);
        $display("test simul done");
    endtask

    task automatic t_all;
        wr(ADR_CTRL, 32'h2);
        set_btn(8'h00, 12);
        set_btn(8'h03, 210);
        set_btn(8'h0f, 16);
        relay(1'b0);
        set_btn(8'h00, 12);
        set_btn(8'h0f, 0);
        relay(1'b1);
        set_btn(8'h00, 16);
        $display("test all done");
    endtask

    // four pairs requested in combined mode are clamped to two
    task automatic t_comb;
        wr(ADR_CTRL, 32'h7);
        wr(ADR_IRQ_MASK, 32'h8);
        cycles(12);
        lamp(1'b1, 2'h2);
        set_btn(8'h0f, 16);
        relay(1'b0);
        set_btn(8'h00, 12);
        ack_p <= 1'b1;
        cycles(6);
        ack_p <= 1'b0;
        set_btn(8'h0f, 0);
        relay(1'b1);
        loop_c <= 1'b0;
        relay(1'b0);
        lamp(1'b0, 2'h2);
        chk({31'h0, irq}, 32'h1);
        wr(ADR_IRQ_STAT, 32'hf);
        loop_c <= 1'b1;
        set_btn(8'h00, 12);
        set_btn(8'h0f, 16);
        relay(1'b0);
        set_btn(8'h00, 12);
        $display("test comb done");
    endtask

    // broken contactor feedback keeps the relays off and flashes the status lamp
    task automatic t_fb;
        wr(ADR_CTRL, 32'h10);
        fb_brk <= 1'b1;
        set_btn(8'h00, 12);
        set_btn(8'h03, 16);
        relay(1'b0);
        lamp(1'b0, 2'h2);
        fb_brk <= 1'b0;
        set_btn(8'h00, 12);
        $display("test feedback done");
    endtask

    task automatic t_switch;
        logic [31:0] q;
        wr(ADR_CTRL, 32'h8);
        transit <= 8'h03;
        set_btn(8'h00, 12);
        set_btn(8'h03, 0);
        relay(1'b1);
        transit <= 8'h14;
        set_btn(8'h00, 30);
        relay(1'b0);
        chk({28'h0, fcode}, 32'h7);
        transit <= 8'h00;
        set_btn(8'h03, 16);
        set_btn(8'h00, 16);
        relay(1'b0);
        wb(1'b0, ADR_STATUS, 32'h0, q);
        chk(q & 32'hf0, 32'h70);
        @(posedge clk);
        rst <= 1'b1;
        cycles(2);
        rst <= 1'b0;
        cycles(2);
        chk({28'h0, fcode}, 32'h0);
        $display("test switch done");
    endtask

    initial begin
        cycles(2);
        rst <= 1'b0;
        t_regs;
        t_pair;
        t_simul;
        t_all;
        t_comb;
        t_fb;
        t_switch;
        end_sim;
    end

    // watchdog well beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
